//--- verilog/plq_pkg.sv
// Package: register map, field layout, reset values and timing counts
package plq_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_THIRD_POLE = 4'h0;
  localparam logic [3:0] OFS_LOCK_CFG = 4'h4;
  localparam logic [3:0] OFS_THRESH = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam logic [3:0] OFS_EVENT = 4'h0;
  localparam logic [3:0] OFS_MASK = 4'h4;
  localparam logic [3:0] OFS_LOL_CNT = 4'h8;
  // Address bank select bit
  localparam int ADDR_BANK_BIT = 4;
  // Third pole register fields
  localparam int TP_BYPASS_BIT = 7;
  localparam int TP_RES_LSB = 4;
  localparam int TP_CAP_LSB = 0;
  localparam logic [2:0] TP_RES_RST = 3'h3;
  localparam logic [2:0] TP_CAP_RST = 3'h7;
  // Lock config fields
  localparam int LC_RAW_BIT = 9;
  localparam int LC_PREC_BIT = 8;
  localparam int LC_TIMER_LSB = 6;
  localparam int LC_ONCE_BIT = 5;
  localparam int LC_CALBYP_BIT = 4;
  localparam int LC_DISABLE_BIT = 3;
  localparam int LC_FILT_LSB = 0;
  localparam logic [1:0] LC_TIMER_RST = 2'h2;
  localparam logic LC_PREC_RST = 1'b1;
  localparam logic [2:0] LC_FILT_RST = 3'h0;
  // Threshold fields
  localparam int TH_HIGH_LSB = 4;
  localparam int TH_LOW_LSB = 0;
  localparam logic [3:0] TH_HIGH_RST = 4'h8;
  localparam logic [3:0] TH_LOW_RST = 4'h8;
  // Status bits
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_CALDONE_BIT = 1;
  localparam int EV_LOL_BIT = 0;
  localparam logic [3:0] LOL_CNT_MAX = 4'hF;
  // Debounce intervals in system clock cycles
  localparam int DEB_CYC_1 = 570;
  localparam int DEB_CYC_2 = 5700;
  localparam int DEB_CYC_3 = 57000;
  localparam int DEB_W = 16;
endpackage

//--- verilog/plq_cfg_if.sv
// Interface: configuration and status between top and lock qualifier
`timescale 1ns/10ps
interface plq_cfg_if;
  logic use_raw;
  logic once_sel;
  logic cal_bypass;
  logic det_disable;
  logic [1:0] timer_sel;
  logic lock_q;
  logic raw_sel;
  modport ctl (output use_raw, output once_sel, output cal_bypass,
    output det_disable, output timer_sel, input lock_q, input raw_sel);
  modport qual (input use_raw, input once_sel, input cal_bypass,
    input det_disable, input timer_sel, output lock_q, output raw_sel);
endinterface

//--- verilog/plq_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module plq_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule

//--- verilog/plq_qual.sv
// Lock qualifier: source gating, debounce, latch-once and force lock
`timescale 1ns/10ps
module plq_qual #(
  parameter int CYC_1 = plq_pkg::DEB_CYC_1,
  parameter int CYC_2 = plq_pkg::DEB_CYC_2,
  parameter int CYC_3 = plq_pkg::DEB_CYC_3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Synchronised analog indications and register precision enable
  input wire logic prec_lock_i,
  input wire logic orig_lock_i,
  input wire logic prec_en_i,
  input wire logic cal_done_i,
  // Configuration and result
  plq_cfg_if.qual cfg
);
  localparam int W = plq_pkg::DEB_W;

  initial begin
    if (CYC_1 < 1 || CYC_2 < 1 || CYC_3 < 1 || CYC_3 >= (1 << W))
      $error("plq_qual: debounce count out of range");
  end

  function automatic logic [W-1:0] interval(input logic [1:0] sel);
    unique case (sel)
      2'h0: interval = '0;
      2'h1: interval = W'(CYC_1);
      2'h2: interval = W'(CYC_2);
      2'h3: interval = W'(CYC_3);
    endcase
  endfunction

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic deb;
  logic next_deb;
  logic held;
  logic next_held;
  logic lock_q;
  logic next_lock_q;
  logic raw_sel;
  logic src;
  logic enable;

  assign cfg.lock_q = lock_q;
  assign cfg.raw_sel = raw_sel;

  always_comb begin
    // [RQ5] precision detector select
    src = prec_en_i ? prec_lock_i : orig_lock_i;
    // [RQ8] gate until calibration done
    enable = cfg.cal_bypass | cal_done_i;
    next_cnt = cnt;
    next_deb = 1'b0;
    // [RQ17] restart count on drop
    if (!(src && enable)) begin
      next_cnt = '0;
    end else if (cnt >= interval(cfg.timer_sel)) begin
      // [RQ6] selected debounce interval
      next_deb = 1'b1;
    end else begin
      next_cnt = W'(cnt + 1'b1);
    end
    // [RQ7] hold once asserted
    next_held = cfg.once_sel & (held | deb);
    // [RQ9] disable forces lock
    next_lock_q = cfg.det_disable | deb | next_held;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      deb <= 1'b0;
      held <= 1'b0;
      lock_q <= 1'b0;
      raw_sel <= 1'b0;
    end else begin
      cnt <= next_cnt;
      deb <= next_deb;
      held <= next_held;
      lock_q <= next_lock_q;
      raw_sel <= src;
    end
  end
endmodule

//--- verilog/plq_top.sv
// Top: PLL lock-detect qualifier with Avalon-MM registers and interrupt
// Overview of operation
// [RQ1] Software sets third-pole bypass only in integer feedback mode.
// [RQ2] Three-bit third-pole resistor field, reset 3, drives analog filter.
// [RQ3] Three-bit third-pole capacitor field, reset 7, drives analog filter.
// [RQ4] Raw-lock routing puts the unqualified selected lock on the pin.
// [RQ5] Precision enable, reset one, selects precision detector source.
// [RQ6] Two-bit timer selects zero, 570, 5700 or 57000 cycle debounce.
// [RQ7] One-time mode latches lock once asserted; else real-time.
// [RQ8] Without calibration bypass, detection waits for calibration done.
// [RQ9] Detector disable forces the lock indication asserted.
// [RQ10] Three-bit lock-detect filter resistor field, reset zero.
// [RQ11] Four-bit high threshold field, reset 8, to analog detector.
// [RQ12] Four-bit low threshold field, reset 8, to analog detector.
// [RQ13] Calibration-done flag readable; gates detection when not bypassed.
// [RQ14] Qualified lock readable as real-time status bit.
// [RQ15] Locked-to-unlocked transition sets sticky write-one-clear event.
// [RQ16] Four-bit saturating loss-of-lock counter, writable by software.
// [RQ17] Debounced lock needs raw lock continuously high for interval.
`timescale 1ns/10ps
module plq_top #(
  parameter int DEB_CYC_1 = plq_pkg::DEB_CYC_1,
  parameter int DEB_CYC_2 = plq_pkg::DEB_CYC_2,
  parameter int DEB_CYC_3 = plq_pkg::DEB_CYC_3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Analog indications
  input wire logic prec_lock_raw_i,
  input wire logic orig_lock_raw_i,
  input wire logic cal_done_raw_i,
  // Analog configuration
  output logic third_pole_bypass_o,
  output logic [2:0] third_pole_resistor_sel_o,
  output logic [2:0] third_pole_capacitor_sel_o,
  output logic precision_en_o,
  output logic [2:0] lock_filter_res_sel_o,
  output logic [3:0] precision_high_threshold_o,
  output logic [3:0] precision_low_threshold_o,
  // Status pin and interrupt
  output logic lock_pin_o,
  output logic irq_o
);
  logic prec_s;
  logic orig_s;
  logic cal_done_s;
  plq_cfg_if cfg_if ();

  plq_sync #(.WIDTH(3)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({prec_lock_raw_i, orig_lock_raw_i, cal_done_raw_i}),
    .q_o({prec_s, orig_s, cal_done_s})
  );

  plq_qual #(.CYC_1(DEB_CYC_1), .CYC_2(DEB_CYC_2), .CYC_3(DEB_CYC_3)) u_qual (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .prec_lock_i(prec_s),
    .orig_lock_i(orig_s),
    .prec_en_i(precision_en_o),
    .cal_done_i(cal_done_s),
    .cfg(cfg_if.qual)
  );

  // Register state
  logic [7:0] tp_reg;
  logic [15:0] lc_reg;
  logic [7:0] th_reg;
  logic lol_evt;
  logic lol_mask;
  logic [3:0] lol_cnt;
  logic lock_d;
  logic ack;
  logic [31:0] rdata;
  logic [7:0] next_tp_reg;
  logic [15:0] next_lc_reg;
  logic [7:0] next_th_reg;
  logic next_lol_evt;
  logic next_lol_mask;
  logic [3:0] next_lol_cnt;
  logic next_ack;
  logic [31:0] next_rdata;
  logic next_lock_pin;
  logic next_irq;
  logic wr;
  logic rd;
  logic lol_fall;
  logic bank;
  logic [3:0] ofs;

  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [7:0] nw,
                                        input logic be);
    merge8 = be ? nw : old;
  endfunction

  assign cfg_if.use_raw = lc_reg[plq_pkg::LC_RAW_BIT];
  assign cfg_if.once_sel = lc_reg[plq_pkg::LC_ONCE_BIT];
  assign cfg_if.cal_bypass = lc_reg[plq_pkg::LC_CALBYP_BIT];
  assign cfg_if.det_disable = lc_reg[plq_pkg::LC_DISABLE_BIT];
  assign cfg_if.timer_sel = lc_reg[plq_pkg::LC_TIMER_LSB +: 2];

  // One wait cycle per access; answer comes on the second edge
  assign wr = avs_write_i & ~ack;
  assign rd = avs_read_i & ~ack;
  assign bank = avs_address_i[plq_pkg::ADDR_BANK_BIT];
  assign ofs = avs_address_i[3:0];

  always_comb begin
    next_tp_reg = tp_reg;
    next_lc_reg = lc_reg;
    next_th_reg = th_reg;
    next_lol_mask = lol_mask;
    next_lol_cnt = lol_cnt;
    next_lol_evt = lol_evt;
    next_ack = (avs_read_i | avs_write_i) & ~ack;
    next_rdata = '0;
    lol_fall = lock_d & ~cfg_if.lock_q;
    if (wr && !bank) begin
      unique case (ofs)
        // [RQ2] resistor, [RQ3] capacitor fields
        plq_pkg::OFS_THIRD_POLE: next_tp_reg = merge8(tp_reg,
          avs_writedata_i[7:0], avs_byteenable_i[0]) & 8'hF7;
        plq_pkg::OFS_LOCK_CFG: begin
          next_lc_reg[7:0] = merge8(lc_reg[7:0], avs_writedata_i[7:0],
            avs_byteenable_i[0]);
          next_lc_reg[15:8] = merge8(lc_reg[15:8], avs_writedata_i[15:8],
            avs_byteenable_i[1]) & 8'h03;
        end
        // [RQ11] [RQ12] threshold fields
        plq_pkg::OFS_THRESH: next_th_reg = merge8(th_reg,
          avs_writedata_i[7:0], avs_byteenable_i[0]);
        default: ;
      endcase
    end
    if (wr && bank && avs_byteenable_i[0]) begin
      unique case (ofs)
        plq_pkg::OFS_EVENT:
          if (avs_writedata_i[plq_pkg::EV_LOL_BIT]) next_lol_evt = 1'b0;
        plq_pkg::OFS_MASK: next_lol_mask = avs_writedata_i[0];
        // [RQ16] software clear or preset
        plq_pkg::OFS_LOL_CNT: next_lol_cnt = avs_writedata_i[3:0];
        default: ;
      endcase
    end
    // [RQ15] event set wins over clear
    if (lol_fall) begin
      next_lol_evt = 1'b1;
    end
    // [RQ16] saturating increment
    if (lol_fall && next_lol_cnt != plq_pkg::LOL_CNT_MAX) begin
      next_lol_cnt = 4'(next_lol_cnt + 4'h1);
    end
    if (rd) begin
      unique case ({bank, ofs})
        {1'b0, plq_pkg::OFS_THIRD_POLE}: next_rdata = {24'h0, tp_reg};
        {1'b0, plq_pkg::OFS_LOCK_CFG}: next_rdata = {16'h0, lc_reg};
        {1'b0, plq_pkg::OFS_THRESH}: next_rdata = {24'h0, th_reg};
        // [RQ13] [RQ14] calibration done and lock status
        {1'b0, plq_pkg::OFS_STATUS}: begin
          next_rdata[plq_pkg::ST_LOCK_BIT] = cfg_if.lock_q;
          next_rdata[plq_pkg::ST_CALDONE_BIT] = cal_done_s;
        end
        {1'b1, plq_pkg::OFS_EVENT}: next_rdata = {31'h0, lol_evt};
        {1'b1, plq_pkg::OFS_MASK}: next_rdata = {31'h0, lol_mask};
        {1'b1, plq_pkg::OFS_LOL_CNT}: next_rdata = {28'h0, lol_cnt};
        default: next_rdata = '0;
      endcase
    end
    // [RQ4] raw lock routing to pin
    next_lock_pin = cfg_if.use_raw ? cfg_if.raw_sel : cfg_if.lock_q;
    next_irq = next_lol_evt & next_lol_mask;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tp_reg <= {1'b0, plq_pkg::TP_RES_RST, 1'b0, plq_pkg::TP_CAP_RST};
      lc_reg <= {6'h00, 1'b0, plq_pkg::LC_PREC_RST, plq_pkg::LC_TIMER_RST,
                 3'h0, plq_pkg::LC_FILT_RST};
      th_reg <= {plq_pkg::TH_HIGH_RST, plq_pkg::TH_LOW_RST};
      lol_evt <= 1'b0;
      lol_mask <= 1'b0;
      lol_cnt <= 4'h0;
      lock_d <= 1'b0;
      ack <= 1'b0;
      avs_readdata_o <= '0;
      lock_pin_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      tp_reg <= next_tp_reg;
      lc_reg <= next_lc_reg;
      th_reg <= next_th_reg;
      lol_evt <= next_lol_evt;
      lol_mask <= next_lol_mask;
      lol_cnt <= next_lol_cnt;
      lock_d <= cfg_if.lock_q;
      ack <= next_ack;
      avs_readdata_o <= next_rdata;
      lock_pin_o <= next_lock_pin;
      irq_o <= next_irq;
    end
  end

  // Waitrequest high except in the answer cycle; a registered output
  logic wait_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~next_ack;
    end
  end
  assign avs_waitrequest_o = wait_q;

  // Analog configuration straight from register bits
  // [RQ1] bypass bit passed as written; integer mode is software's duty
  assign third_pole_bypass_o = tp_reg[plq_pkg::TP_BYPASS_BIT];
  assign third_pole_resistor_sel_o = tp_reg[plq_pkg::TP_RES_LSB +: 3];
  assign third_pole_capacitor_sel_o = tp_reg[plq_pkg::TP_CAP_LSB +: 3];
  assign precision_en_o = lc_reg[plq_pkg::LC_PREC_BIT];
  // [RQ10] filter resistor select
  assign lock_filter_res_sel_o = lc_reg[plq_pkg::LC_FILT_LSB +: 3];
  assign precision_high_threshold_o = th_reg[plq_pkg::TH_HIGH_LSB +: 4];
  assign precision_low_threshold_o = th_reg[plq_pkg::TH_LOW_LSB +: 4];
endmodule

//--- tb/plq_checker.sv
// Checker: bus, configuration and lock pin properties
`timescale 1ns/10ps
module plq_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic [4:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  // Analog side
  input wire logic prec_lock_raw_i,
  input wire logic orig_lock_raw_i,
  input wire logic cal_done_raw_i,
  input wire logic [2:0] third_pole_resistor_sel_o,
  input wire logic [2:0] third_pole_capacitor_sel_o,
  input wire logic precision_en_o,
  input wire logic [2:0] lock_filter_res_sel_o,
  input wire logic [3:0] precision_high_threshold_o,
  input wire logic [3:0] precision_low_threshold_o,
  // Pin and interrupt
  input wire logic lock_pin_o,
  input wire logic irq_o
);
  // Route, once, bypass, disable; lags the design, so writes are masked
  logic [3:0] m;
  logic [3:0] next_m;
  logic src;
  assign src = precision_en_o ? prec_lock_raw_i : orig_lock_raw_i;
  always_comb begin
    next_m = m;
    if (avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h04) begin
      if (avs_byteenable_i[1]) next_m[3] = avs_writedata_i[9];
      if (avs_byteenable_i[0]) next_m[2:0] = avs_writedata_i[5:3];
    end
  end
  always_ff @(posedge clk_i) m <= rst_i ? 4'h0 : next_m;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_raw_hi;
    (m[3] && !avs_write_i && src) [*6];
  endsequence
  sequence s_cal_low;
    (m == 4'h0 && !avs_write_i && !cal_done_raw_i) [*8];
  endsequence
  property p_rst_cfg;
    $fell(rst_i) |-> third_pole_resistor_sel_o == 3'h3 &&
      third_pole_capacitor_sel_o == 3'h7 && precision_en_o &&
      lock_filter_res_sel_o == 3'h0 && precision_high_threshold_o == 4'h8
      && precision_low_threshold_o == 4'h8;
  endproperty
  property p_raw; s_raw_hi |-> lock_pin_o; endproperty
  property p_once;
    m[2] && !m[3] && !avs_write_i && lock_pin_o |=> lock_pin_o;
  endproperty
  property p_cal; s_cal_low |-> !lock_pin_o; endproperty
  property p_dis; m[0] && !m[3] && !avs_write_i |-> ##[0:4] lock_pin_o;
  endproperty
  property p_irq; $fell(irq_o) |-> $past(avs_write_i); endproperty
  property p_deb;
    !m[0] && !m[3] && !avs_write_i && $rose(lock_pin_o) |-> $past(src, 2);
  endproperty
  property p_wait; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_rst_cfg: assert property (p_rst_cfg)
    else $error("config outputs not at reset values");
  a_raw: assert property (p_raw)
    else $error("raw source not on lock pin");
  a_once: assert property (p_once)
    else $error("latched lock dropped");
  a_cal: assert property (p_cal)
    else $error("lock seen before calibration done");
  a_dis: assert property (p_dis)
    else $error("disabled detector did not force lock");
  a_irq: assert property (p_irq)
    else $error("interrupt fell without a write");
  a_deb: assert property (p_deb)
    else $error("lock rose without source high");
  a_wait: assert property (p_wait)
    else $error("waitrequest low for more than one cycle");
endmodule
bind plq_top plq_checker i_plq_checker (.clk_i, .rst_i, .avs_address_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o,
  .prec_lock_raw_i, .orig_lock_raw_i, .cal_done_raw_i,
  .third_pole_resistor_sel_o, .third_pole_capacitor_sel_o, .precision_en_o,
  .lock_filter_res_sel_o, .precision_high_threshold_o,
  .precision_low_threshold_o, .lock_pin_o, .irq_o);

//--- tb/plq_analog.sv
// Partner: analog lock comparators and calibration done level
`timescale 1ns/10ps
module plq_analog (
  // Clock
  input wire logic clk_i,
  // Levels asked for
  input wire logic prec_i,
  input wire logic orig_i,
  input wire logic cal_i,
  // Levels to the block
  output logic prec_o,
  output logic orig_o,
  output logic cal_o
);
  // Levels settle one clock after they are asked for
  always_ff @(posedge clk_i) begin
    prec_o <= prec_i;
    orig_o <= orig_i;
    cal_o <= cal_i;
  end
endmodule

//--- tb/testbench.sv
// Testbench: registers, debounce, events, gating and routing
`timescale 1ns/10ps
module testbench;
  logic clk_i = 0;
  logic rst_i = 1;
  logic [4:0] avs_address_i = 0;
  logic avs_read_i = 0;
  logic avs_write_i = 0;
  logic [31:0] avs_writedata_i = 0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o, q;
  logic avs_waitrequest_o, prec_lock_raw_i, orig_lock_raw_i, cal_done_raw_i;
  logic third_pole_bypass_o, precision_en_o, lock_pin_o, irq_o;
  logic [2:0] third_pole_resistor_sel_o, third_pole_capacitor_sel_o;
  logic [2:0] lock_filter_res_sel_o;
  logic [3:0] precision_high_threshold_o, precision_low_threshold_o;
  logic pw = 0, ow = 0, cw = 0;
  logic [31:0] mdl [32];
  int mismatches = 0, checked = 0, n;
  int iv [4] = '{0, 3, 5, 9};
  integer seed = 32'h54be;
  always #20 clk_i = ~clk_i;
  plq_top #(.DEB_CYC_1(3), .DEB_CYC_2(5), .DEB_CYC_3(9)) i_plq_top (.*);
  plq_analog i_plq_analog (.clk_i, .prec_i(pw), .orig_i(ow), .cal_i(cw),
    .prec_o(prec_lock_raw_i), .orig_o(orig_lock_raw_i),
    .cal_o(cal_done_raw_i));
  function automatic logic [31:0] msk(input logic [4:0] a);
    case (a)
      5'h00: return 32'hF7;
      5'h04: return 32'h3FF;
      5'h08: return 32'hFF;
      5'h14: return 32'h1;
      5'h18: return 32'hF;
      default: return 32'h0;
    endcase
  endfunction
  task automatic chk(input string s, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    if (k >= 20) mismatches++;
    q = avs_readdata_o;
    avs_write_i <= 0;
    avs_read_i <= 0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1, a, d);
    if (a == 5'h10) mdl[a] = mdl[a] & ~d;
    else if (a != 5'h0C) mdl[a] = d & msk(a);
  endtask
  task automatic rc(input logic [4:0] a);
    bus(0, a, 0);
    chk($sformatf("reg %h", a), mdl[a], q);
  endtask
  task automatic wt(input logic v);
    n = 0;
    while (lock_pin_o !== v && n < 60) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    foreach (mdl[i]) mdl[i] = 0;
    mdl[0] = 32'h37;
    mdl[4] = 32'h180;
    mdl[8] = 32'h88;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    for (int a = 0; a < 32; a += 4) rc(a[4:0]);
    $display("reset values done");
    repeat (4) begin
      wr(5'h00, $random(seed) & 32'h7F);
      wr(5'h04, $random(seed) & 32'h307);
      wr(5'h08, $random(seed));
      rc(5'h00);
      rc(5'h04);
      rc(5'h08);
      chk("pole", mdl[0], {third_pole_bypass_o, third_pole_resistor_sel_o,
        1'b0, third_pole_capacitor_sel_o});
      chk("thr", mdl[8], {precision_high_threshold_o,
        precision_low_threshold_o});
      chk("lcfg", {mdl[4][8], mdl[4][2:0]}, {precision_en_o,
        lock_filter_res_sel_o});
    end
    // Integer feedback assumed while the third pole is bypassed
    wr(5'h00, 32'hF5);
    chk("bypass", 1, third_pole_bypass_o);
    $display("config done");
    wr(5'h14, 32'h1);
    wr(5'h18, 32'hD);
    cw <= 1;
    for (int c = 0; c < 4; c++) begin
      wr(5'h04, 32'h100 | (c << 6));
      if (c == 3) begin
        pw <= 1;
        repeat (6) @(posedge clk_i);
        pw <= 0;
        repeat (2) @(posedge clk_i);
      end
      pw <= 1;
      wt(1);
      chk("debounce", 1, n > iv[c] && n <= iv[c] + 10);
      mdl[12] = 3;
      rc(5'h0C);
      pw <= 0;
      wt(0);
      mdl[16] = 1;
      mdl[24] = mdl[24] < 15 ? mdl[24] + 1 : 15;
      repeat (2) @(posedge clk_i);
      chk("irq", 1, irq_o);
      mdl[12] = 2;
      rc(5'h0C);
      rc(5'h10);
      rc(5'h18);
      wr(5'h10, 32'h1);
      @(posedge clk_i);
      chk("irq", 0, irq_o);
    end
    $display("debounce and events done");
    wr(5'h04, 32'h120);
    pw <= 1;
    wt(1);
    pw <= 0;
    repeat (10) @(posedge clk_i);
    chk("once", 1, lock_pin_o);
    wr(5'h04, 32'h100);
    cw <= 0;
    pw <= 1;
    repeat (20) @(posedge clk_i);
    chk("cal", 0, lock_pin_o);
    mdl[12] = 0;
    rc(5'h0C);
    wr(5'h04, 32'h110);
    wt(1);
    chk("calbyp", 1, lock_pin_o);
    pw <= 0;
    wt(0);
    wr(5'h04, 32'h008);
    wt(1);
    chk("disable", 1, lock_pin_o);
    wr(5'h04, 32'h200);
    repeat (6) begin
      ow <= 1'($random(seed));
      repeat (6) @(posedge clk_i);
      chk("raw", ow, lock_pin_o);
    end
    $display("gating and routing done");
    end_of_test;
  end
  initial begin
    #(40 * 8000);
    mismatches++;
    end_of_test;
  end
endmodule
